/* core/ssic_pkg.sv */
/*
 * Package for the synchronous burst SRAM input-capture block: widths,
 * burst order encodings, a cycle-type enum and the packed struct that
 * carries the control pins.
 * Assumes a single clock domain; all inputs are synchronous to it.
 */
package ssic_pkg;
    localparam int ADDR_W_DEF  = 18;
    localparam int LANES_DEF   = 4;
    localparam int LANE_BITS   = 9;
    localparam int BURST_W     = 2;
    localparam logic [1:0] BURST_ONE   = 2'h1;
    localparam logic [1:0] BURST_ZERO  = 2'h0;
    localparam logic       ORDER_LIN   = 1'b0;
    localparam logic       ORDER_INTLV = 1'b1;
    localparam real        CLK_MHZ     = 40.0;

    typedef enum logic [1:0] {
        SSIC_IDLE,
        SSIC_READ,
        SSIC_WRITE
    } ssic_op_e;

    typedef struct packed {
        logic primary_select_n;
        logic depth_select_hi;
        logic depth_select_lo_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic all_bytes_write_n;
        logic byte_write_qualifier_n;
    } ssic_ctrl_s;
endpackage

/* core/ssic_lane_decode.sv */
/*
 * Byte-lane write decode: turns global write, qualifier and per-lane
 * selects into one write strobe per lane.
 * Assumes inputs are the raw pins; outputs are sampled at the rising clock edge.
 */
`timescale 1ns/1ps
module ssic_lane_decode
    import ssic_pkg::*;
#(
    parameter int LANES = LANES_DEF
) (
    input  wire logic             all_bytes_write_n_in,      // Global write
    input  wire logic             byte_write_qualifier_n_in, // Qualifier
    input  wire logic [LANES-1:0] byte_lane_write_n_in,      // Lane selects
    output logic      [LANES-1:0] lane_write_out,            // Lane writes
    output logic                  is_write_out               // Any write
);
    wire logic global_wr = ~all_bytes_write_n_in;
    wire logic qual_wr   = ~byte_write_qualifier_n_in;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // Global write overrides qualifier and selects
            assign lane_write_out[g] = global_wr |
                (qual_wr & ~byte_lane_write_n_in[g]);
        end
    endgenerate

    // Qualifier low with no lane selected is still a write cycle
    assign is_write_out = global_wr | qual_wr;
endmodule

/* core/ssic_input_ctrl.sv */
/*
 * Input capture and control decode for a pipelined synchronous burst
 * SRAM: address register, two-bit burst counter, selection and
 * byte-lane write decode.
 * Assumes a single clock, inputs synchronous to it, and a bus master
 * that keeps the strap static.
 */
`timescale 1ns/1ps
module ssic_input_ctrl
    import ssic_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF
) (
    input  wire logic              clk_in,               // 40 MHz clock
    input  wire logic              rst_b_in,             // Sync reset, low
    input  wire logic              clk_en_in,            // Freeze when low
    input  wire logic [ADDR_W-1:0] addr_in,              // Address pins
    input  wire ssic_ctrl_s        ctrl_in,              // Control pins
    input  wire logic [LANES-1:0]  byte_lane_write_n_in, // Lane selects
    input  wire logic              order_strap_in,       // Burst order
    output logic [ADDR_W-1:0]      addr_out,             // Array address
    output logic [BURST_W-1:0]     burst_count_out,      // Raw counter
    output logic                   selected_out,         // Cycle active
    output logic                   write_out,            // Write cycle
    output logic [LANES-1:0]       lane_write_out,       // Lane writes
    output logic                   load_out              // New address
);
    // Counter bits sit below the loaded base, so the address is wider
    if (ADDR_W <= BURST_W || LANES < 1) begin : g_bad_param
        $error("ssic_input_ctrl: bad parameters");
    end

    ////////////////////////////////////////////////////////////////////
    // Selection and strobe decode
    wire logic chip_sel = ~ctrl_in.primary_select_n &
                          ctrl_in.depth_select_hi &
                          ~ctrl_in.depth_select_lo_n;
    wire logic proc_go  = ~ctrl_in.proc_addr_strobe_n &
                          ~ctrl_in.primary_select_n;
    // Controller strobe is overshadowed by an active processor strobe
    wire logic ctrl_go  = ~ctrl_in.ctrl_addr_strobe_n &
                          ~proc_go;
    // Selects matter only when a strobe asks for an external load
    wire logic load_ext = (proc_go | ctrl_go) & chip_sel;
    // A disregarded processor strobe neither loads nor deselects
    wire logic strobe   = proc_go |
                          ~ctrl_in.ctrl_addr_strobe_n;
    wire logic deselect = strobe & ~load_ext;
    wire logic advance  = ~ctrl_in.burst_advance_n & ~strobe &
                          selected_out;

    ////////////////////////////////////////////////////////////////////
    // Write decode; processor-strobe cycles are always reads
    wire logic [LANES-1:0] lane_wr;
    wire logic             is_wr;
    ssic_lane_decode #(.LANES(LANES)) u_lane (
        .all_bytes_write_n_in      (ctrl_in.all_bytes_write_n),
        .byte_write_qualifier_n_in (ctrl_in.byte_write_qualifier_n),
        .byte_lane_write_n_in      (byte_lane_write_n_in),
        .lane_write_out            (lane_wr),
        .is_write_out              (is_wr)
    );
    wire logic wr_now = is_wr & ~proc_go;

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [BURST_W-1:0] start_reg;
    logic [BURST_W-1:0] count_next;
    logic               order_reg;

    wire logic [BURST_W-1:0] count_inc = burst_count_out + BURST_ONE;
    assign count_next = load_ext ? addr_in[BURST_W-1:0] :
                        advance  ? count_inc : burst_count_out;

    // Next array address, worked out ahead so addr_out leaves a flop;
    // linear follows the count, interleaved XORs start with the step
    wire logic [BURST_W-1:0] start_next =
        load_ext ? addr_in[BURST_W-1:0] : start_reg;
    wire logic [BURST_W-1:0] offs    = count_next - start_next;
    wire logic [BURST_W-1:0] low_int = start_next ^ offs;
    wire logic [BURST_W-1:0] low_sel =
        (order_strap_in == ORDER_INTLV) ? low_int : count_next;
    wire logic [ADDR_W-1:0]  addr_next = load_ext ?
        {addr_in[ADDR_W-1:BURST_W], low_sel} :
        {addr_out[ADDR_W-1:BURST_W], low_sel};

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            addr_out        <= '0;
            start_reg       <= BURST_ZERO;
            burst_count_out <= BURST_ZERO;
            selected_out    <= 1'b0;
            write_out       <= 1'b0;
            lane_write_out  <= '0;
            load_out        <= 1'b0;
            order_reg       <= ORDER_INTLV;
        end else if (clk_en_in) begin
            order_reg       <= order_strap_in;
            burst_count_out <= count_next;
            load_out        <= load_ext;
            addr_out        <= addr_next;
            if (load_ext) begin
                start_reg <= addr_in[BURST_W-1:0];
            end
            if (load_ext || deselect)
                selected_out <= load_ext;
            // Writes during a burst follow the current controls
            if (load_ext || advance || (selected_out && !strobe)) begin
                write_out      <= load_ext ? wr_now : is_wr;
                lane_write_out <= (load_ext ? wr_now : is_wr) ?
                                  lane_wr : '0;
            end else if (deselect) begin
                write_out      <= 1'b0;
                lane_write_out <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_load;
        clk_en_in && load_ext;
    endsequence

    a_load_copies_low: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        s_load |=> burst_count_out == $past(addr_in[BURST_W-1:0]))
        else $error("burst counter not loaded from address");

    a_no_load_desel: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && !chip_sel |=> !load_out)
        else $error("load taken while deselected");

    a_proc_ignored: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && ctrl_in.primary_select_n &&
        ctrl_in.ctrl_addr_strobe_n |=> !load_out)
        else $error("processor strobe honoured with select high");

    sequence s_advance;
        clk_en_in && advance && !load_ext;
    endsequence

    a_advance_step: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        s_advance |=>
        burst_count_out == $past(burst_count_out) + BURST_ONE)
        else $error("burst counter did not advance");

    a_hold_no_adv: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && !strobe && ctrl_in.burst_advance_n |=>
        $stable(burst_count_out) && $stable(selected_out))
        else $error("state changed without strobe or advance");

    a_global_all: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && load_ext && !proc_go &&
        !ctrl_in.all_bytes_write_n |=> lane_write_out == '1)
        else $error("global write missed a lane");

    a_lane_qual: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && load_ext && ctrl_in.all_bytes_write_n &&
        ctrl_in.byte_write_qualifier_n |=> lane_write_out == '0)
        else $error("lane write without qualifier");

    a_read_cycle: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        s_load ##1 (clk_en_in && !write_out) |-> lane_write_out == '0)
        else $error("read cycle shows lane writes");

    a_both_strobes: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && load_ext && !ctrl_in.proc_addr_strobe_n |=>
        !write_out)
        else $error("controller strobe acted on with processor strobe");

    a_depth_sel: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && (!ctrl_in.depth_select_hi ||
        ctrl_in.depth_select_lo_n) && strobe |=> !selected_out)
        else $error("selected with depth select inactive");

    a_order_lin: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        order_reg == ORDER_LIN |-> addr_out[BURST_W-1:0] ==
        burst_count_out)
        else $error("linear order address mismatch");

    a_proc_disregard: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && ctrl_in.primary_select_n &&
        !ctrl_in.proc_addr_strobe_n && ctrl_in.ctrl_addr_strobe_n &&
        ctrl_in.burst_advance_n |=> $stable(selected_out) && !load_out)
        else $error("processor strobe not disregarded");

    a_freeze_hold: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        !clk_en_in |=> $stable(addr_out) && $stable(burst_count_out) &&
        $stable(selected_out) && $stable(lane_write_out))
        else $error("state moved while clock enable low");

    a_lane_follow: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        clk_en_in && load_ext && !proc_go && ctrl_in.all_bytes_write_n &&
        !ctrl_in.byte_write_qualifier_n |=>
        lane_write_out == ~$past(byte_lane_write_n_in))
        else $error("lane writes do not follow the lane selects");
endmodule

/* tb/ssic_bus_model.sv */
/*
 * Bus model of the processor or cache controller that faces the SRAM
 * input block: drives address, control and lane-select pins.
 * Assumes the bench calls put once per cycle, at most.
 */
`timescale 1ns/1ps
module ssic_bus_model
    import ssic_pkg::*;
(
    input  wire logic              clk_in,     // Bus clock
    output logic [ADDR_W_DEF-1:0]  addr_out,   // Address pins
    output ssic_ctrl_s             ctrl_out,   // Control pins
    output logic [LANES_DEF-1:0]   lane_n_out  // Lane selects, low
);
    initial begin
        addr_out   = '0;
        ctrl_out   = 8'h5F;
        lane_n_out = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////
    // Pins change at the falling edge, half a cycle clear of sampling
    task automatic put(input logic [ADDR_W_DEF-1:0] a,
                       input logic [7:0] c, input logic [3:0] l);
        @(negedge clk_in);
        addr_out   = a;
        ctrl_out   = c;
        lane_n_out = l;
    endtask
endmodule

/* tb/sync_sram_input_control_tb_top.sv */
/*
 * Self-checking bench for ssic_input_ctrl: one task per scenario.
 * Assumes default widths and the bus model on the input pins.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module sync_sram_input_control_tb_top
    import ssic_pkg::*;
;
    logic                  clk_in    = 1'b0;
    logic                  rst_b_in  = 1'b0;
    logic                  clk_en_in = 1'b1;
    logic                  order_strap_in = ORDER_LIN;
    logic                  en_nx     = 1'b1;
    logic                  strap_nx  = ORDER_LIN;
    logic [ADDR_W_DEF-1:0] addr_in, addr_out;
    ssic_ctrl_s            ctrl_in;
    logic [LANES_DEF-1:0]  lane_n, lane_write_out;
    logic [BURST_W-1:0]    burst_count_out;
    logic                  selected_out, write_out, load_out;
    logic [7:0]            dsel [4] = '{8'hCF, 8'h17, 8'h77, 8'hC7};
    // First pattern is a processor strobe under a high primary select
    logic                  dsel_sel [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    int                    n_fail   = 0;
    int                    compares = 0;
    always #12.5 clk_in = ~clk_in;
    ssic_bus_model i_ssic_bus_model (.clk_in(clk_in), .addr_out(addr_in),
        .ctrl_out(ctrl_in), .lane_n_out(lane_n));
    ssic_input_ctrl i_ssic_input_ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in), .addr_in(addr_in), .ctrl_in(ctrl_in),
        .byte_lane_write_n_in(lane_n), .order_strap_in(order_strap_in),
        .addr_out(addr_out), .burst_count_out(burst_count_out),
        .selected_out(selected_out), .write_out(write_out),
        .lane_write_out(lane_write_out), .load_out(load_out));
    ////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Strap and enable ride with the pins so they share one edge
    task automatic step(input logic [17:0] a, input logic [7:0] c,
                        input logic [3:0] l);
        i_ssic_bus_model.put(a, c, l);
        clk_en_in      = en_nx;
        order_strap_in = strap_nx;
        @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic ld, sl, wr, input logic [3:0] ln,
                       input logic [1:0] ct);
        `CHK(load_out, ld)
        `CHK(selected_out, sl)
        `CHK(write_out, wr)
        `CHK(lane_write_out, ln)
        `CHK(burst_count_out, ct)
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_burst();
        step(18'h2_3456, 8'h55, 4'hF);
        chk(1, 1, 1, 4'hF, 2'h2);
        `CHK(addr_out, 18'h2_3456)
        step(18'h1_0000, 8'h5B, 4'hF);
        chk(0, 1, 0, 4'h0, 2'h3);
        // Primary select high must not end an advancing burst
        step(18'h1_0000, 8'hDB, 4'hF);
        chk(0, 1, 0, 4'h0, 2'h0);
        `CHK(addr_out, 18'h2_3454)
    endtask
    task automatic t_intlv();
        strap_nx = ORDER_INTLV;
        step(18'h1_0001, 8'h57, 4'h0);
        chk(1, 1, 0, 4'h0, 2'h1);
        step(18'h2_0000, 8'h5B, 4'hF);
        `CHK(addr_out, 18'h1_0000)
        en_nx = 1'b0;
        step(18'h2_0000, 8'h5B, 4'hF);
        `CHK(burst_count_out, 2'h2)
        en_nx = 1'b1;
        step(18'h2_0000, 8'h5B, 4'hF);
        `CHK(addr_out, 18'h1_0003)
    endtask
    task automatic t_lanes();
        step(18'h0_0010, 8'h56, 4'hA);
        chk(1, 1, 1, 4'h5, 2'h0);
        step(18'h0_0020, 8'h57, 4'h0);
        chk(1, 1, 0, 4'h0, 2'h0);
        step(18'h0_0030, 8'h56, 4'hF);
        chk(1, 1, 1, 4'h0, 2'h0);
        step(18'h0_0040, 8'h54, 4'hA);
        chk(1, 1, 1, 4'hF, 2'h0);
    endtask
    task automatic t_strobes();
        step(18'h0_0103, 8'h45, 4'hF);
        chk(1, 1, 0, 4'h0, 2'h3);
        `CHK(addr_out, 18'h0_0103)
        foreach (dsel[i]) begin
            step(18'h0_0100, 8'h57, 4'hF);
            step(18'h0_0200, dsel[i], 4'hF);
            `CHK(load_out, 1'b0)
            `CHK(selected_out, dsel_sel[i])
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        chk(0, 0, 0, 4'h0, 2'h0);
        @(negedge clk_in);
        rst_b_in = 1'b1;
        t_burst();
        t_intlv();
        t_lanes();
        t_strobes();
        summarize();
    end
    initial begin
        repeat (2000) @(posedge clk_in);
        n_fail++;
        summarize();
    end
endmodule
